/* File: thermal_alarm_pkg.sv */
package thermal_alarm_pkg;

	// Fixed upper nibble of the slave address
	localparam logic [3:0] ADDR_FIXED = 4'h9;

	// Register pointer codes
	localparam logic [1:0] PTR_TEMP = 2'h0;
	localparam logic [1:0] PTR_CFG = 2'h1;
	localparam logic [1:0] PTR_HYST = 2'h2;
	localparam logic [1:0] PTR_TRIP = 2'h3;

	// Values after reset, half degree per step, two's complement
	localparam logic [8:0] TEMP_RST = 9'h000;
	localparam logic [8:0] TRIP_RST = 9'h0C8;
	localparam logic [8:0] HYST_RST = 9'h0BE;
	localparam logic [7:0] CFG_RST = 8'h00;

	// Bit positions within a nine-clock byte slot
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;

	// Byte order within a write access
	localparam logic [1:0] BYTE_PTR = 2'h0;
	localparam logic [1:0] BYTE_HI = 2'h1;
	localparam logic [1:0] BYTE_LO = 2'h2;
	localparam logic [1:0] BYTE_END = 2'h3;

	// Fault filter codes and the run lengths they ask for
	localparam logic [1:0] FQ_1 = 2'h0;
	localparam logic [1:0] FQ_2 = 2'h1;
	localparam logic [1:0] FQ_4 = 2'h2;
	localparam logic [2:0] RUN_Q1 = 3'h1;
	localparam logic [2:0] RUN_Q2 = 3'h2;
	localparam logic [2:0] RUN_Q4 = 3'h4;
	localparam logic [2:0] RUN_Q6 = 3'h6;
	localparam logic [2:0] RUN_MAX = 3'h7;

	typedef struct packed {
		logic [2:0] zero;
		logic [1:0] queue;
		logic polarity;
		logic mode;
		logic shutdown;
	} cfg_t;

	typedef struct packed {
		logic [1:0] idx;
		logic [7:0] data;
	} wr_word_t;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} rd_pair_t;

	typedef enum logic [1:0] {
		ST_ADDR = 2'h0,
		ST_WRITE = 2'h1,
		ST_READ = 2'h3,
		ST_IGNORE = 2'h2
	} link_state_t;

endpackage

/* File: thermal_alarm_serial_slave.sv */
`timescale 1ns/1ps
// Functional notes
// - Comparator: alarm active when temperature above trip
// - Comparator: alarm holds until below hysteresis
// - Interrupt: trip sets alarm, any read clears
// - Interrupt: later drop below hysteresis sets again
// - Interrupt: alarm holds until a register read or shutdown entry
// - Shutdown entry in interrupt mode clears alarm
// - Shutdown in comparator mode keeps alarm state
// - Alarm polarity programmable, active low after reset
// - Alarm pin is open drain, pulls low only
// - Shutdown stops new conversions
// - Serial port and registers work during shutdown
// - Alarm changes after N equal consecutive results
// - Bus ignored until a start condition
// - Stop condition ends the transfer
// - Acknowledge only matching address and pins
// - Address last bit: one read, zero write
// - Device pulls data low on ninth clock
// - Acknowledge every written data byte
// - Bytes shifted most significant bit first
// - Data changes only while clock low
// - Device is slave, never drives clock
// - Two-bit pointer selects the register
// - Filter field picks 1, 2, 4 or 6
// - Values are two's complement half degrees
module thermal_alarm_serial_slave (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic addr_sel_hi_i,
	input wire logic addr_sel_mid_i,
	input wire logic addr_sel_lo_i,
	input wire logic alarm_out_i,
	output logic alarm_out_o,
	output logic alarm_out_oe_n_o,
	input wire logic conv_valid_i,
	input wire logic [8:0] conv_temp_i,
	output logic conv_en_o
);

////////////////////////////////////////////////////////////////////////////
// Bus line watch in the system clock domain

logic scl_s1_q, scl_s2_q, scl_d_q;
logic sda_s1_q, sda_s2_q, sda_d_q;
logic start_det, stop_det;

always_ff @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		scl_s1_q <= 1'b1;
		scl_s2_q <= 1'b1;
		scl_d_q <= 1'b1;
		sda_s1_q <= 1'b1;
		sda_s2_q <= 1'b1;
		sda_d_q <= 1'b1;
	end else begin
		scl_s1_q <= scl_i;
		scl_s2_q <= scl_s1_q;
		scl_d_q <= scl_s2_q;
		sda_s1_q <= sda_i;
		sda_s2_q <= sda_s1_q;
		sda_d_q <= sda_s2_q;
	end
end

assign start_det = scl_s2_q && scl_d_q && sda_d_q && !sda_s2_q;
assign stop_det = scl_s2_q && scl_d_q && !sda_d_q && sda_s2_q;

// The link logic sits in reset outside a frame. Release waits for the
// clock low after a start, so no clock edge falls near the release.
logic frame_rst_q, rel_pend_q;

always_ff @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		frame_rst_q <= 1'b1;
		rel_pend_q <= 1'b0;
	end else if (start_det) begin
		frame_rst_q <= 1'b1;
		rel_pend_q <= 1'b1;
	end else if (stop_det) begin
		frame_rst_q <= 1'b1;
		rel_pend_q <= 1'b0;
	end else if (rel_pend_q && !scl_s2_q) begin
		frame_rst_q <= 1'b0;
		rel_pend_q <= 1'b0;
	end
end

a_start_opens: assert property (@(posedge clk_i) disable iff (rst_i)
	start_det |=> frame_rst_q && rel_pend_q)
	else $error("start did not open a frame");

sequence s_stop_seen;
	stop_det ##1 (frame_rst_q && !rel_pend_q);
endsequence

a_stop_closes: assert property (@(posedge clk_i) disable iff (rst_i)
	stop_det |-> s_stop_seen)
	else $error("stop did not close the frame");

////////////////////////////////////////////////////////////////////////////
// Serial link on the host clock; sampled on rise, driven on fall

logic [2:0] addr_s1_q, addr_s2_q;
thermal_alarm_pkg::link_state_t state_q;
logic [3:0] bit_q;
logic [7:0] shift_q, rx_byte, tx_byte;
logic ack_q, rd_idx_q, addr_hit, byte_last, ack_slot;
logic [1:0] byte_q;
logic wr_tgl_q, rd_tgl_q;
logic sda_oe_n_q;
thermal_alarm_pkg::wr_word_t wr_word_q;
thermal_alarm_pkg::rd_pair_t shadow_q;

// Pin straps are static, so they carry no reset
always_ff @(posedge scl_i) begin
	addr_s1_q <= {addr_sel_hi_i, addr_sel_mid_i, addr_sel_lo_i};
	addr_s2_q <= addr_s1_q;
end

assign rx_byte = {shift_q[6:0], sda_i};
assign byte_last = bit_q == thermal_alarm_pkg::BIT_LAST;
assign ack_slot = bit_q == thermal_alarm_pkg::BIT_ACK;
assign addr_hit = rx_byte[7:4] == thermal_alarm_pkg::ADDR_FIXED
	&& rx_byte[3:1] == addr_s2_q;

always_ff @(posedge scl_i or posedge frame_rst_q) begin
	if (frame_rst_q) begin
		state_q <= thermal_alarm_pkg::ST_ADDR;
		bit_q <= 4'h0;
		shift_q <= 8'h00;
		ack_q <= 1'b0;
		byte_q <= thermal_alarm_pkg::BYTE_PTR;
		rd_idx_q <= 1'b0;
	end else if (ack_slot) begin
		bit_q <= 4'h0;
		ack_q <= 1'b0;
		if (state_q == thermal_alarm_pkg::ST_READ && !ack_q) begin
			// Host not acknowledging ends the read until stop
			if (sda_i) begin
				state_q <= thermal_alarm_pkg::ST_IGNORE;
			end
			rd_idx_q <= !rd_idx_q;
		end
	end else begin
		bit_q <= bit_q + 4'h1;
		shift_q <= rx_byte;
		if (byte_last) begin
			case (state_q)
			thermal_alarm_pkg::ST_ADDR: begin
				if (addr_hit) begin
					ack_q <= 1'b1;
					state_q <= rx_byte[0] ? thermal_alarm_pkg::ST_READ
						: thermal_alarm_pkg::ST_WRITE;
				end else begin
					state_q <= thermal_alarm_pkg::ST_IGNORE;
				end
			end
			thermal_alarm_pkg::ST_WRITE: begin
				ack_q <= 1'b1;
				if (byte_q != thermal_alarm_pkg::BYTE_END) begin
					byte_q <= byte_q + 2'h1;
				end
			end
			default: begin
				ack_q <= 1'b0;
			end
			endcase
		end
	end
end

// Events to the system domain survive the stop, so only rst_i clears them
always_ff @(posedge scl_i or posedge rst_i) begin
	if (rst_i) begin
		wr_tgl_q <= 1'b0;
		rd_tgl_q <= 1'b0;
		wr_word_q <= '0;
	end else if (byte_last) begin
		if (state_q == thermal_alarm_pkg::ST_WRITE) begin
			wr_word_q <= '{idx: byte_q, data: rx_byte};
			wr_tgl_q <= !wr_tgl_q;
		end
		if (state_q == thermal_alarm_pkg::ST_ADDR && addr_hit && rx_byte[0]) begin
			rd_tgl_q <= !rd_tgl_q;
		end
	end
end

assign tx_byte = rd_idx_q ? shadow_q.lo : shadow_q.hi;

// Of the two bus lines only data is ever driven; the clock is an input only
always_ff @(negedge scl_i or posedge frame_rst_q) begin
	if (frame_rst_q) begin
		sda_oe_n_q <= 1'b1;
	end else if (ack_slot) begin
		sda_oe_n_q <= !ack_q;
	end else if (state_q == thermal_alarm_pkg::ST_READ) begin
		sda_oe_n_q <= tx_byte[3'(thermal_alarm_pkg::BIT_LAST - bit_q)];
	end else begin
		sda_oe_n_q <= 1'b1;
	end
end

a_addr_reject: assert property (@(posedge scl_i) disable iff (frame_rst_q)
	(state_q == thermal_alarm_pkg::ST_ADDR && byte_last && !addr_hit)
	|=> (state_q == thermal_alarm_pkg::ST_IGNORE && !ack_q))
	else $error("foreign address was accepted");

a_dir_select: assert property (@(posedge scl_i) disable iff (frame_rst_q)
	(state_q == thermal_alarm_pkg::ST_ADDR && byte_last && addr_hit)
	|=> state_q == ($past(sda_i) ? thermal_alarm_pkg::ST_READ
		: thermal_alarm_pkg::ST_WRITE))
	else $error("direction bit misread");

a_ack_drive: assert property (@(posedge scl_i) disable iff (frame_rst_q)
	(ack_slot && ack_q) |-> !sda_oe_n_q)
	else $error("acknowledge not driven on ninth clock");

////////////////////////////////////////////////////////////////////////////
// Registers in the system domain

logic wr_s1_q, wr_s2_q, wr_d_q, rd_s1_q, rd_s2_q, rd_d_q;
logic wr_evt, rd_evt;
logic [1:0] ptr_q;
logic [8:0] trip_q, hyst_q, temp_q;
thermal_alarm_pkg::cfg_t cfg_q;
thermal_alarm_pkg::rd_pair_t rd_sel;

always_ff @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		wr_s1_q <= 1'b0;
		wr_s2_q <= 1'b0;
		wr_d_q <= 1'b0;
		rd_s1_q <= 1'b0;
		rd_s2_q <= 1'b0;
		rd_d_q <= 1'b0;
	end else begin
		wr_s1_q <= wr_tgl_q;
		wr_s2_q <= wr_s1_q;
		wr_d_q <= wr_s2_q;
		rd_s1_q <= rd_tgl_q;
		rd_s2_q <= rd_s1_q;
		rd_d_q <= rd_s2_q;
	end
end

assign wr_evt = wr_s2_q ^ wr_d_q;
assign rd_evt = rd_s2_q ^ rd_d_q;

// The written word stays put for a whole byte slot after its toggle
always_ff @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		ptr_q <= thermal_alarm_pkg::PTR_TEMP;
		cfg_q <= thermal_alarm_pkg::CFG_RST;
		trip_q <= thermal_alarm_pkg::TRIP_RST;
		hyst_q <= thermal_alarm_pkg::HYST_RST;
	end else if (wr_evt) begin
		case (wr_word_q.idx)
		thermal_alarm_pkg::BYTE_PTR: begin
			ptr_q <= wr_word_q.data[1:0];
		end
		thermal_alarm_pkg::BYTE_HI: begin
			case (ptr_q)
			thermal_alarm_pkg::PTR_CFG: cfg_q <= wr_word_q.data;
			thermal_alarm_pkg::PTR_HYST: hyst_q[8:1] <= wr_word_q.data;
			thermal_alarm_pkg::PTR_TRIP: trip_q[8:1] <= wr_word_q.data;
			default: begin
			end
			endcase
		end
		thermal_alarm_pkg::BYTE_LO: begin
			case (ptr_q)
			thermal_alarm_pkg::PTR_HYST: hyst_q[0] <= wr_word_q.data[7];
			thermal_alarm_pkg::PTR_TRIP: trip_q[0] <= wr_word_q.data[7];
			default: begin
			end
			endcase
		end
		default: begin
		end
		endcase
	end
end

always_comb begin
	case (ptr_q)
	thermal_alarm_pkg::PTR_CFG: rd_sel = '{hi: cfg_q, lo: cfg_q};
	thermal_alarm_pkg::PTR_HYST: rd_sel = '{hi: hyst_q[8:1],
		lo: {hyst_q[0], 7'h00}};
	thermal_alarm_pkg::PTR_TRIP: rd_sel = '{hi: trip_q[8:1],
		lo: {trip_q[0], 7'h00}};
	default: rd_sel = '{hi: temp_q[8:1], lo: {temp_q[0], 7'h00}};
	endcase
end

// Read data only moves while the link sits in reset, so it is steady
// for the whole frame as seen from the host clock.
always_ff @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		shadow_q <= '0;
	end else if (frame_rst_q) begin
		shadow_q <= rd_sel;
	end
end

////////////////////////////////////////////////////////////////////////////
// Conversion results, fault filter and alarm

logic conv_ok, hot, cold, fire, sd_prev_q, sd_rise, armed_q, alarm_q;
logic [1:0] last_cls_q;
logic [2:0] run_q, run_d, need;
logic alarm_oe_n_q, conv_en_q, od_zero_q;

assign conv_ok = conv_valid_i && !cfg_q.shutdown;
assign hot = $signed(conv_temp_i) > $signed(trip_q);
assign cold = $signed(conv_temp_i) < $signed(hyst_q);
assign sd_rise = cfg_q.shutdown && !sd_prev_q;

always_comb begin
	case (cfg_q.queue)
	thermal_alarm_pkg::FQ_1: need = thermal_alarm_pkg::RUN_Q1;
	thermal_alarm_pkg::FQ_2: need = thermal_alarm_pkg::RUN_Q2;
	thermal_alarm_pkg::FQ_4: need = thermal_alarm_pkg::RUN_Q4;
	default: need = thermal_alarm_pkg::RUN_Q6;
	endcase
end

always_comb begin
	if ({hot, cold} != last_cls_q) begin
		run_d = thermal_alarm_pkg::RUN_Q1;
	end else if (run_q == thermal_alarm_pkg::RUN_MAX) begin
		run_d = thermal_alarm_pkg::RUN_MAX;
	end else begin
		run_d = run_q + 3'h1;
	end
end

// Acts on every result once the run is long enough, so a steady reading
// still drives the comparator; armed_q keeps interrupt events single
assign fire = conv_ok && (hot || cold) && run_d >= need;

always_ff @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		temp_q <= thermal_alarm_pkg::TEMP_RST;
		run_q <= 3'h0;
		last_cls_q <= 2'h0;
	end else if (conv_ok) begin
		temp_q <= conv_temp_i;
		run_q <= run_d;
		last_cls_q <= {hot, cold};
	end
end

always_ff @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		sd_prev_q <= 1'b0;
	end else begin
		sd_prev_q <= cfg_q.shutdown;
	end
end

// A new event wins over a read in the same cycle
always_ff @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		alarm_q <= 1'b0;
		armed_q <= 1'b0;
	end else if (!cfg_q.mode) begin
		if (fire && hot) begin
			alarm_q <= 1'b1;
		end else if (fire && cold) begin
			alarm_q <= 1'b0;
		end
	end else if (fire && hot && !armed_q) begin
		alarm_q <= 1'b1;
		armed_q <= 1'b1;
	end else if (fire && cold && armed_q) begin
		alarm_q <= 1'b1;
		armed_q <= 1'b0;
	end else if (rd_evt || sd_rise) begin
		alarm_q <= 1'b0;
	end
end

// Pull low when the pin level for the present state is low
always_ff @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		alarm_oe_n_q <= 1'b1;
		conv_en_q <= 1'b1;
		od_zero_q <= 1'b0;
	end else begin
		alarm_oe_n_q <= alarm_q ~^ cfg_q.polarity;
		conv_en_q <= !cfg_q.shutdown;
		od_zero_q <= 1'b0;
	end
end

assign alarm_out_o = od_zero_q;
assign alarm_out_oe_n_o = alarm_oe_n_q;
assign sda_o = od_zero_q;
assign sda_oe_n_o = sda_oe_n_q;
assign conv_en_o = conv_en_q;

////////////////////////////////////////////////////////////////////////////
// Checks on the alarm path

logic pol_w;
assign pol_w = cfg_q.polarity;

sequence s_int_held;
	cfg_q.mode && alarm_q && !rd_evt && !sd_rise;
endsequence

sequence s_cold_event;
	cfg_q.mode && fire && cold && armed_q;
endsequence

a_cmp_trip_set: assert property (@(posedge clk_i) disable iff (rst_i)
	(!cfg_q.mode && fire && hot) |=> alarm_q)
	else $error("comparator alarm not set above trip");

a_cmp_hyst_clr: assert property (@(posedge clk_i) disable iff (rst_i)
	(!cfg_q.mode && fire && cold && !hot) |=> !alarm_q)
	else $error("comparator alarm not cleared below hysteresis");

a_int_read_clr: assert property (@(posedge clk_i) disable iff (rst_i)
	(cfg_q.mode && rd_evt && !fire) |=> !alarm_q)
	else $error("read did not clear interrupt alarm");

a_int_cold_set: assert property (@(posedge clk_i) disable iff (rst_i)
	s_cold_event |=> alarm_q && !armed_q)
	else $error("cold event did not raise alarm");

a_int_hold: assert property (@(posedge clk_i) disable iff (rst_i)
	s_int_held |=> alarm_q)
	else $error("interrupt alarm dropped without read");

a_sd_int_clr: assert property (@(posedge clk_i) disable iff (rst_i)
	(cfg_q.mode && sd_rise) |=> !alarm_q)
	else $error("shutdown did not clear interrupt alarm");

a_sd_cmp_keep: assert property (@(posedge clk_i) disable iff (rst_i)
	(!cfg_q.mode && cfg_q.shutdown) |=> $stable(alarm_q))
	else $error("comparator alarm moved in shutdown");

a_pin_level: assert property (@(posedge clk_i) disable iff (rst_i)
	1'b1 |=> alarm_out_oe_n_o == ($past(alarm_q) ~^ $past(pol_w)))
	else $error("alarm pin level wrong for polarity");

a_od_only: assert property (@(posedge clk_i) disable iff (rst_i)
	!alarm_out_o && !sda_o)
	else $error("open drain pin driven high");

a_conv_halt: assert property (@(posedge clk_i) disable iff (rst_i)
	cfg_q.shutdown |=> !conv_en_o)
	else $error("conversions not halted in shutdown");

a_filter_gate: assert property (@(posedge clk_i) disable iff (rst_i)
	(!fire && !rd_evt && !sd_rise) |=> $stable(alarm_q))
	else $error("alarm moved without a qualified result");

endmodule

/* File: host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model (
	output logic scl_o,
	output logic sda_pull_o,
	input wire logic sda_i
);
	// Clock stands high between frames; only the host ever moves it
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	task automatic start();
		sda_pull_o = 1'b0;
		#7.5 scl_o = 1'b1;
		#15 sda_pull_o = 1'b1;
		#15 scl_o = 1'b0;
		// Slave opens its frame only once it has seen the clock low
		#15;
	endtask

	task automatic stop();
		sda_pull_o = 1'b1;
		#7.5 scl_o = 1'b1;
		#15 sda_pull_o = 1'b0;
		#15;
	endtask

	// Eight data bits then the acknowledge slot; a one in tx releases
	// the line so the slave may pull it in that slot
	task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sda_pull_o = !tx[i];
			#7.5 scl_o = 1'b1;
			#15 rx[i] = sda_i;
			scl_o = 1'b0;
			#7.5;
		end
	endtask
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
	localparam logic [2:0] PINS = 3'h5;
	localparam logic [7:0] ADR_W = {thermal_alarm_pkg::ADDR_FIXED, PINS, 1'b0};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic conv_valid_i = 1'b0;
	logic [8:0] conv_temp_i = 9'h000;
	logic scl, pull, sda_w, alarm_w;
	logic sda_o, sda_oe_n_o, alarm_out_o, alarm_out_oe_n_o, conv_en_o;
	logic [8:0] rx;
	logic [7:0] hi, lo;
	int errors = 0;
	int compares = 0;

	always #2.5 clk_i = !clk_i;
	// Both wires are open drain with pull-ups
	assign sda_w = !(pull || (!sda_oe_n_o && !sda_o));
	assign alarm_w = !(!alarm_out_oe_n_o && !alarm_out_o);

	host_bus_model host_u (.scl_o(scl), .sda_pull_o(pull), .sda_i(sda_w));

	thermal_alarm_serial_slave dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
		.addr_sel_hi_i(PINS[2]), .addr_sel_mid_i(PINS[1]),
		.addr_sel_lo_i(PINS[0]), .alarm_out_i(alarm_w),
		.alarm_out_o(alarm_out_o), .alarm_out_oe_n_o(alarm_out_oe_n_o),
		.conv_valid_i(conv_valid_i), .conv_temp_i(conv_temp_i),
		.conv_en_o(conv_en_o)
	);

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		$display("counts: %0d compares, %0d errors", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [1:0] p, input logic [7:0] a,
		input logic [7:0] b, input int n);
		host_u.start();
		host_u.byte_io({ADR_W, 1'b1}, rx);
		chk(rx[0], 1'b0);
		host_u.byte_io({6'h00, p, 1'b1}, rx);
		chk(rx[0], 1'b0);
		for (int i = 0; i < n; i++) begin
			host_u.byte_io({(i == 0) ? a : b, 1'b1}, rx);
			chk(rx[0], 1'b0);
		end
		host_u.stop();
		repeat (4) @(posedge clk_i);
	endtask

	// Pointer in one frame, then a read frame ending with a refusal
	task automatic rd(input logic [1:0] p);
		wr(p, 8'h00, 8'h00, 0);
		host_u.start();
		host_u.byte_io({ADR_W | 8'h01, 1'b1}, rx);
		chk(rx[0], 1'b0);
		host_u.byte_io(9'h1FE, rx);
		hi = rx[8:1];
		host_u.byte_io(9'h1FF, rx);
		lo = rx[8:1];
		host_u.stop();
		repeat (4) @(posedge clk_i);
	endtask

	task automatic conv(input logic [8:0] t, input int n);
		repeat (n) begin
			@(posedge clk_i);
			conv_valid_i <= 1'b1;
			conv_temp_i <= t;
			@(posedge clk_i);
			conv_valid_i <= 1'b0;
		end
		repeat (6) @(posedge clk_i);
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk({sda_oe_n_o, alarm_out_oe_n_o, conv_en_o}, 3'h7);
		chk({sda_o, alarm_out_o}, 2'h0);
		rd(thermal_alarm_pkg::PTR_TEMP);
		chk({hi, lo}, 16'h0000);
		rd(thermal_alarm_pkg::PTR_CFG);
		chk(hi, thermal_alarm_pkg::CFG_RST);
		rd(thermal_alarm_pkg::PTR_TRIP);
		chk({hi, lo}, {thermal_alarm_pkg::TRIP_RST, 7'h00});
		$display("test reset done");
	endtask

	task automatic t_addr();
		logic [7:0] m[4] = '{8'h80, 8'h10, 8'h08, 8'h02};
		// Address clocked without a start must be ignored
		host_u.byte_io({ADR_W, 1'b1}, rx);
		chk(rx[0], 1'b1);
		host_u.stop();
		for (int i = 0; i < 4; i++) begin
			host_u.start();
			host_u.byte_io({ADR_W ^ m[i], 1'b1}, rx);
			chk(rx[0], 1'b1);
			host_u.byte_io({8'h03, 1'b1}, rx);
			chk(rx[0], 1'b1);
			host_u.stop();
		end
		$display("test address done");
	endtask

	task automatic t_regs();
		wr(thermal_alarm_pkg::PTR_TRIP, 8'h12, 8'h80, 2);
		rd(thermal_alarm_pkg::PTR_TRIP);
		chk({hi, lo}, 16'h1280);
		wr(thermal_alarm_pkg::PTR_HYST, 8'hF8, 8'h00, 2);
		rd(thermal_alarm_pkg::PTR_HYST);
		chk({hi, lo}, 16'hF800);
		wr(thermal_alarm_pkg::PTR_TEMP, 8'h55, 8'h80, 2);
		rd(thermal_alarm_pkg::PTR_TEMP);
		chk({hi, lo}, 16'h0000);
		wr(thermal_alarm_pkg::PTR_CFG, 8'h10, 8'h00, 1);
		rd(thermal_alarm_pkg::PTR_CFG);
		chk({hi, lo}, 16'h1010);
		wr(thermal_alarm_pkg::PTR_CFG, 8'h00, 8'h00, 1);
		$display("test registers done");
	endtask

	// Trip is 0x025, hysteresis 0x1F0 (negative)
	task automatic t_cmp();
		conv(9'h025, 1);
		chk(alarm_w, 1'b1);
		conv(9'h026, 1);
		chk(alarm_w, 1'b0);
		conv(9'h000, 1);
		chk(alarm_w, 1'b0);
		conv(9'h1F0, 1);
		chk(alarm_w, 1'b0);
		conv(9'h1E0, 1);
		chk(alarm_w, 1'b1);
		rd(thermal_alarm_pkg::PTR_TEMP);
		chk({hi, lo}, 16'hF000);
		$display("test comparator done");
	endtask

	task automatic t_filter();
		int runs[4] = '{1, 2, 4, 6};
		for (int c = 0; c < 4; c++) begin
			wr(thermal_alarm_pkg::PTR_CFG, {3'h0, c[1:0], 3'h0}, 8'h00, 1);
			conv(9'h026, runs[c] - 1);
			chk(alarm_w, 1'b1);
			conv(9'h026, 1);
			chk(alarm_w, 1'b0);
			conv(9'h1E0, runs[c] - 1);
			chk(alarm_w, 1'b0);
			conv(9'h1E0, 1);
			chk(alarm_w, 1'b1);
		end
		$display("test filter done");
	endtask

	task automatic t_int();
		wr(thermal_alarm_pkg::PTR_CFG, 8'h02, 8'h00, 1);
		conv(9'h026, 1);
		chk(alarm_w, 1'b0);
		conv(9'h000, 3);
		chk(alarm_w, 1'b0);
		rd(thermal_alarm_pkg::PTR_HYST);
		chk(alarm_w, 1'b1);
		conv(9'h1E0, 1);
		chk(alarm_w, 1'b0);
		conv(9'h000, 2);
		chk(alarm_w, 1'b0);
		rd(thermal_alarm_pkg::PTR_CFG);
		chk(alarm_w, 1'b1);
		wr(thermal_alarm_pkg::PTR_CFG, 8'h06, 8'h00, 1);
		chk(alarm_w, 1'b0);
		conv(9'h026, 1);
		chk(alarm_w, 1'b1);
		wr(thermal_alarm_pkg::PTR_CFG, 8'h07, 8'h00, 1);
		chk(alarm_w, 1'b0);
		chk(conv_en_o, 1'b0);
		$display("test interrupt done");
	endtask

	task automatic t_shut();
		conv(9'h050, 1);
		rd(thermal_alarm_pkg::PTR_TEMP);
		chk({hi, lo}, 16'h1300);
		wr(thermal_alarm_pkg::PTR_TRIP, 8'h20, 8'h00, 2);
		rd(thermal_alarm_pkg::PTR_TRIP);
		chk({hi, lo}, 16'h2000);
		wr(thermal_alarm_pkg::PTR_CFG, 8'h00, 8'h00, 1);
		chk(conv_en_o, 1'b1);
		conv(9'h050, 1);
		chk(alarm_w, 1'b0);
		wr(thermal_alarm_pkg::PTR_CFG, 8'h01, 8'h00, 1);
		chk({alarm_w, conv_en_o}, 2'h0);
		conv(9'h1E0, 1);
		chk(alarm_w, 1'b0);
		wr(thermal_alarm_pkg::PTR_CFG, 8'h00, 8'h00, 1);
		conv(9'h1E0, 1);
		chk(alarm_w, 1'b1);
		$display("test shutdown done");
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		t_reset();
		t_addr();
		t_regs();
		t_cmp();
		t_filter();
		t_int();
		t_shut();
		close_out();
	end

	// Whole run needs well under 150 us
	initial begin
		#400000;
		errors++;
		close_out();
	end
endmodule
